// [common/output_disable_defines.svh]
/*
 * Register offsets, field positions, reset values and sizes of the
 * output driver disable control block.
 * Assumes byte-wide registers on a 16-bit register address.
 */
`ifndef OUTPUT_DISABLE_DEFINES_SVH
`define OUTPUT_DISABLE_DEFINES_SVH

// Sizes
`define NUM_DRIVERS 7
`define NUM_LOOPS 4
`define ADDR_W 16
`define DATA_W 8

// Status registers
`define CALIB_AND_CRYSTAL_STATUS_ADDR 16'h000C
`define LOOP_LOCK_LOSS_STATUS_ADDR 16'h000D
`define STAT_CALIB_BIT 0
`define STAT_CRYSTAL_BIT 1

// Global gate and masks
`define GLOBAL_OUTPUT_GATE_ADDR 16'h0102
`define GLOBAL_GATE_BIT 0
`define CRYSTAL_LOSS_MASK_ADDR 16'h0141
`define CRYSTAL_MASK_BIT 6
`define LOCK_LOSS_MASK_ADDR 16'h0142

// Per-driver control bytes
`define DRIVER0_ENABLE_CTRL_ADDR 16'h0112
`define DRIVER1_ENABLE_CTRL_ADDR 16'h0117
`define DRIVER2_ENABLE_CTRL_ADDR 16'h011C
`define DRIVER3_ENABLE_CTRL_ADDR 16'h0126
`define DRIVER4_ENABLE_CTRL_ADDR 16'h012B
`define DRIVER5_ENABLE_CTRL_ADDR 16'h0130
`define DRIVER6_ENABLE_CTRL_ADDR 16'h013A
`define DRIVER0_DISABLE_CTRL_ADDR 16'h0113
`define DRIVER1_DISABLE_CTRL_ADDR 16'h0118
`define DRIVER2_DISABLE_CTRL_ADDR 16'h011D
`define DRIVER3_DISABLE_CTRL_ADDR 16'h0127
`define DRIVER4_DISABLE_CTRL_ADDR 16'h012C
`define DRIVER5_DISABLE_CTRL_ADDR 16'h0131
`define DRIVER6_DISABLE_CTRL_ADDR 16'h013B
`define DRIVER_ENABLE_BIT 1
`define SYNC_SELECT_BIT 3
`define LEVEL_LSB 4
`define LEVEL_MSB 5
`define LEVEL_HIGH 2'h1

// Reset values
`define GLOBAL_GATE_RESET 1'h1
`define DRIVER_ENABLE_RESET 1'h0
`define SYNC_SELECT_RESET 1'h0
`define LEVEL_RESET 2'h0
`define LOCK_MASK_RESET 4'hF
`define CRYSTAL_MASK_RESET 1'h0

`endif

// [common/output_disable_pkg.sv]
/*
 * Types shared by the output driver disable control block.
 * Assumes output_disable_defines.svh is on the include path.
 */
`default_nettype none
`include "output_disable_defines.svh"

package output_disable_pkg;

	// One register access from the configuration port
	typedef struct packed {
		logic write;
		logic read;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
	} reg_req_s;

	// Automatic disable sources from the rest of the device
	typedef struct packed {
		logic [`NUM_LOOPS-1:0] loop_lock_loss_flags;
		logic crystal_input_loss;
		logic calibration_in_progress;
	} alarm_in_s;

	// Whole state of the control block
	typedef struct packed {
		logic global_output_gate;
		logic [`NUM_DRIVERS-1:0] per_driver_enable;
		logic [`NUM_DRIVERS-1:0] synchronous_disable_select;
		logic [`NUM_DRIVERS-1:0][1:0] disabled_level_select;
		logic [`NUM_LOOPS-1:0] lock_loss_disable_mask;
		logic crystal_loss_disable_mask;
		logic crystal_loss_alarm;
		logic [`NUM_DRIVERS-1:0] driver_active;
		logic [`NUM_DRIVERS-1:0] driver_out;
		logic [`DATA_W-1:0] rdata;
	} ctrl_state_s;

endpackage

`default_nettype wire

// [design/output_driver_disable_control.sv]
/*
 * Output driver disable control: per-driver enable gating, automatic
 * disable sources, synchronous or immediate disable and disabled level.
 * Assumes driver clocks, alarms and register accesses are synchronous
 * to clk and that driver clocks run well below clk.
 */
`default_nettype none
`include "output_disable_defines.svh"

module output_driver_disable_control (
	input wire logic clk,
	input wire logic reset,
	input wire output_disable_pkg::reg_req_s reg_req,
	output logic [`DATA_W-1:0] reg_rdata,
	input wire logic output_enable_pin_n,
	input wire output_disable_pkg::alarm_in_s alarms,
	input wire logic [2*`NUM_DRIVERS-1:0] driver_disable_source_select,
	input wire logic [`NUM_DRIVERS-1:0] driver_clk_in,
	output logic [`NUM_DRIVERS-1:0] driver_out,
	output logic [`NUM_DRIVERS-1:0] driver_enabled
);

	////////////////////////////////////////////////////////////////////
	// Address tables

	localparam logic [`NUM_DRIVERS-1:0][`ADDR_W-1:0] ENABLE_ADDR = {
		`DRIVER6_ENABLE_CTRL_ADDR, `DRIVER5_ENABLE_CTRL_ADDR,
		`DRIVER4_ENABLE_CTRL_ADDR, `DRIVER3_ENABLE_CTRL_ADDR,
		`DRIVER2_ENABLE_CTRL_ADDR, `DRIVER1_ENABLE_CTRL_ADDR,
		`DRIVER0_ENABLE_CTRL_ADDR
	};
	localparam logic [`NUM_DRIVERS-1:0][`ADDR_W-1:0] DISABLE_ADDR = {
		`DRIVER6_DISABLE_CTRL_ADDR, `DRIVER5_DISABLE_CTRL_ADDR,
		`DRIVER4_DISABLE_CTRL_ADDR, `DRIVER3_DISABLE_CTRL_ADDR,
		`DRIVER2_DISABLE_CTRL_ADDR, `DRIVER1_DISABLE_CTRL_ADDR,
		`DRIVER0_DISABLE_CTRL_ADDR
	};

	output_disable_pkg::ctrl_state_s state_reg;
	output_disable_pkg::ctrl_state_s state_next;

	logic [`NUM_DRIVERS-1:0] want_enable;
	logic [`NUM_DRIVERS-1:0] lock_loss_hit;
	logic [`NUM_DRIVERS-1:0] enable_hit;
	logic [`NUM_DRIVERS-1:0] disable_hit;
	logic crystal_disable;
	logic global_disable;

	////////////////////////////////////////////////////////////////////
	// Sources that hit every driver alike

	// Crystal loss acts through the registered alarm, one cycle late
	assign crystal_disable = state_reg.crystal_loss_alarm
		& ~state_reg.crystal_loss_disable_mask;
	// Gate and pin are not maskable; calibration neither
	assign global_disable = output_enable_pin_n
		| ~state_reg.global_output_gate
		| crystal_disable
		| alarms.calibration_in_progress;

	////////////////////////////////////////////////////////////////////
	// Per-driver request and address decode

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_DRIVERS; gi++) begin : g_drv
			logic [1:0] src;
			assign src = driver_disable_source_select[2*gi +: 2];
			// Only the loop this driver is assigned to can stop it
			assign lock_loss_hit[gi] = alarms.loop_lock_loss_flags[src]
				& ~state_reg.lock_loss_disable_mask[src];
			// Any unmasked source wins over the enable bit
			assign want_enable[gi] = state_reg.per_driver_enable[gi]
				& ~global_disable & ~lock_loss_hit[gi];
			assign enable_hit[gi] = (reg_req.addr == ENABLE_ADDR[gi]);
			assign disable_hit[gi] = (reg_req.addr == DISABLE_ADDR[gi]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_next = state_reg;

		// Crystal alarm follows the raw loss indication
		state_next.crystal_loss_alarm = alarms.crystal_input_loss;

		// Register writes
		if (reg_req.write) begin
			case (reg_req.addr)
				`GLOBAL_OUTPUT_GATE_ADDR: begin
					state_next.global_output_gate =
						reg_req.wdata[`GLOBAL_GATE_BIT];
				end
				`CRYSTAL_LOSS_MASK_ADDR: begin
					state_next.crystal_loss_disable_mask =
						reg_req.wdata[`CRYSTAL_MASK_BIT];
				end
				`LOCK_LOSS_MASK_ADDR: begin
					state_next.lock_loss_disable_mask =
						reg_req.wdata[`NUM_LOOPS-1:0];
				end
				default: begin
				end
			endcase
			for (int i = 0; i < `NUM_DRIVERS; i++) begin
				if (enable_hit[i]) begin
					state_next.per_driver_enable[i] =
						reg_req.wdata[`DRIVER_ENABLE_BIT];
				end
				if (disable_hit[i]) begin
					state_next.synchronous_disable_select[i] =
						reg_req.wdata[`SYNC_SELECT_BIT];
					state_next.disabled_level_select[i] =
						reg_req.wdata[`LEVEL_MSB:`LEVEL_LSB];
				end
			end
		end

		// Register reads; unmapped offsets answer zero
		state_next.rdata = 8'h00;
		if (reg_req.read) begin
			case (reg_req.addr)
				`CALIB_AND_CRYSTAL_STATUS_ADDR: begin
					state_next.rdata[`STAT_CALIB_BIT] = alarms.calibration_in_progress;
					state_next.rdata[`STAT_CRYSTAL_BIT] = state_reg.crystal_loss_alarm;
				end
				`LOOP_LOCK_LOSS_STATUS_ADDR: begin
					state_next.rdata[`NUM_LOOPS-1:0] = alarms.loop_lock_loss_flags;
				end
				`GLOBAL_OUTPUT_GATE_ADDR: begin
					state_next.rdata[`GLOBAL_GATE_BIT] = state_reg.global_output_gate;
				end
				`CRYSTAL_LOSS_MASK_ADDR: begin
					state_next.rdata[`CRYSTAL_MASK_BIT] =
						state_reg.crystal_loss_disable_mask;
				end
				`LOCK_LOSS_MASK_ADDR: begin
					state_next.rdata[`NUM_LOOPS-1:0] = state_reg.lock_loss_disable_mask;
				end
				default: begin
				end
			endcase
			for (int i = 0; i < `NUM_DRIVERS; i++) begin
				if (enable_hit[i]) begin
					state_next.rdata[`DRIVER_ENABLE_BIT] = state_reg.per_driver_enable[i];
				end
				if (disable_hit[i]) begin
					state_next.rdata[`SYNC_SELECT_BIT] =
						state_reg.synchronous_disable_select[i];
					state_next.rdata[`LEVEL_MSB:`LEVEL_LSB] =
						state_reg.disabled_level_select[i];
				end
			end
		end

		// Driver gating; sync mode holds the state while the clock is
		// high so neither a cut nor a late-started high phase can occur
		for (int i = 0; i < `NUM_DRIVERS; i++) begin
			if (state_reg.synchronous_disable_select[i] && driver_clk_in[i]) begin
				state_next.driver_active[i] = state_reg.driver_active[i];
			end else begin
				state_next.driver_active[i] = want_enable[i];
			end
			if (state_next.driver_active[i]) begin
				state_next.driver_out[i] = driver_clk_in[i];
			end else begin
				// Reserved level codes fall back to low
				state_next.driver_out[i] =
					(state_reg.disabled_level_select[i] == `LEVEL_HIGH);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg.global_output_gate <= `GLOBAL_GATE_RESET;
			state_reg.per_driver_enable <= {`NUM_DRIVERS{`DRIVER_ENABLE_RESET}};
			state_reg.synchronous_disable_select <= {`NUM_DRIVERS{`SYNC_SELECT_RESET}};
			state_reg.disabled_level_select <= {`NUM_DRIVERS{`LEVEL_RESET}};
			state_reg.lock_loss_disable_mask <= `LOCK_MASK_RESET;
			state_reg.crystal_loss_disable_mask <= `CRYSTAL_MASK_RESET;
			state_reg.crystal_loss_alarm <= 1'h0;
			state_reg.driver_active <= 7'h00;
			state_reg.driver_out <= 7'h00;
			state_reg.rdata <= 8'h00;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = state_reg.rdata;
	assign driver_out = state_reg.driver_out;
	assign driver_enabled = state_reg.driver_active;

endmodule

`default_nettype wire

// [testbench/clock_load_model.sv]
/* Downstream clock load: counts rising edges seen on driver 0.
   Assumes loads are sampled on the block clock. */
`default_nettype none
module clock_load_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [6:0] load_in,
	output logic [15:0] edge_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev_reg;
	// Edge counter; a load cannot tell runts apart, only count them
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prev_reg <= 1'b0;
			edge_count <= 16'h0000;
		end else begin
			prev_reg <= load_in[0];
			if (load_in[0] && !prev_reg) edge_count <= edge_count + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// [testbench/disable_checker.sv]
/* Port-level properties of the driver disable block.
   Assumes it is bound to output_driver_disable_control. */
`default_nettype none
`include "output_disable_defines.svh"
module disable_checker (
	input wire logic clk,
	input wire logic reset,
	input wire output_disable_pkg::reg_req_s reg_req,
	input wire logic [`DATA_W-1:0] reg_rdata,
	input wire logic output_enable_pin_n,
	input wire output_disable_pkg::alarm_in_s alarms,
	input wire logic [2*`NUM_DRIVERS-1:0] driver_disable_source_select,
	input wire logic [`NUM_DRIVERS-1:0] driver_clk_in,
	input wire logic [`NUM_DRIVERS-1:0] driver_out,
	input wire logic [`NUM_DRIVERS-1:0] driver_enabled
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// Gate write then read back
	sequence s_gate_wr;
		reg_req.write && reg_req.addr == 16'h0102;
	endsequence
	sequence s_gate_rd;
		reg_req.read && !reg_req.write && reg_req.addr == 16'h0102;
	endsequence
	property p_gate_rw;
		s_gate_wr ##2 s_gate_rd |=> reg_rdata == {7'h00, $past(reg_req.wdata[0], 3)};
	endproperty
	property p_pin_off;
		output_enable_pin_n && driver_clk_in == 7'h00 |=> driver_enabled == 7'h00;
	endproperty
	property p_cal_off;
		alarms.calibration_in_progress && driver_clk_in == 7'h00 |=> driver_enabled == 7'h00;
	endproperty
	// A driver may only start while the pin is low and no calibration runs
	property p_rise_cause;
		|(driver_enabled & ~$past(driver_enabled))
			|-> !$past(output_enable_pin_n) && !$past(alarms.calibration_in_progress);
	endproperty
	// Disabled level is steady unless a write could have moved it
	property p_lvl_stable;
		driver_enabled == 7'h00 && $past(driver_enabled) == 7'h00 && !$past(reg_req.write)
			&& !$past(reg_req.write, 2) && !$past(reg_req.write, 3) |-> $stable(driver_out);
	endproperty
	property p_unmapped;
		reg_req.read && reg_req.addr == 16'h0200 |=> reg_rdata == 8'h00;
	endproperty
	property p_rdata_pulse;
		!reg_req.read |=> reg_rdata == 8'h00;
	endproperty
	property p_status_flags;
		reg_req.read && reg_req.addr == 16'h000D
			|=> reg_rdata == {4'h0, $past(alarms.loop_lock_loss_flags)};
	endproperty
	a_gate_rw: assert property (p_gate_rw) else $error("gate readback wrong");
	a_pin_off: assert property (p_pin_off) else $error("pin high, driver on");
	a_cal_off: assert property (p_cal_off) else $error("calibration, driver on");
	a_rise_cause: assert property (p_rise_cause) else $error("bad enable");
	a_lvl_stable: assert property (p_lvl_stable) else $error("level moved");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
	a_rdata_pulse: assert property (p_rdata_pulse) else $error("rdata held");
	a_status_flags: assert property (p_status_flags) else $error("flags wrong");
endmodule
`default_nettype wire

// [testbench/output_driver_disable_control_tb.sv]
/* Bench for the driver disable block: tasks per scenario.
   Assumes the defines header is on the include path. */
`default_nettype none
`include "output_disable_defines.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("mismatch %0t got %h", $time, (a)); end end
module output_driver_disable_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, output_enable_pin_n = 1;
	output_disable_pkg::reg_req_s reg_req = '0;
	output_disable_pkg::alarm_in_s alarms = '0;
	logic [13:0] driver_disable_source_select = 14'h0001;
	logic [6:0] driver_clk_in = 7'h00, driver_out, driver_enabled;
	logic [7:0] reg_rdata;
	logic [15:0] edge_count, e0;
	int n_checks = 0, fail_count = 0, cycles = 0;
	output_driver_disable_control dut_u (.clk, .reset, .reg_req, .reg_rdata,
		.output_enable_pin_n, .alarms, .driver_disable_source_select, .driver_clk_in,
		.driver_out, .driver_enabled);
	clock_load_model load_u (.clk, .reset, .load_in(driver_out), .edge_count);
	////////////////////////////////////////
	// Clock and hang guard
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) reg_req <= '0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) reg_req <= '0;
		#1 `CHK(reg_rdata, e)
	endtask
	////////////////////////////////////////
	task t_reset;
		logic [15:0] a[6] = '{16'h0102, 16'h0112, 16'h0113, 16'h0142, 16'h0141, 16'h0200};
		logic [7:0] e[6] = '{8'h01, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) rd(a[i], e[i]);
	endtask
	task t_enable;
		@(posedge clk) output_enable_pin_n <= 1'b0;
		wr(16'h0112, 8'h02);
		wr(16'h0113, 8'h10);
		step(2);
		`CHK(driver_enabled[0], 1'b1)
		e0 = edge_count;
		// Four source periods must reach the load untouched
		repeat (8) @(posedge clk) driver_clk_in[0] <= ~driver_clk_in[0];
		step(3);
		`CHK(edge_count, e0 + 16'h0004)
		@(posedge clk) output_enable_pin_n <= 1'b1;
		step(2);
		`CHK(driver_enabled[0], 1'b0)
		`CHK(driver_out[0], 1'b1)
		@(posedge clk) output_enable_pin_n <= 1'b0;
		wr(16'h0102, 8'h00);
		step(2);
		`CHK(driver_enabled[0], 1'b0)
		wr(16'h0102, 8'h01);
		rd(16'h0102, 8'h01);
	endtask
	task t_lock;
		wr(16'h0142, 8'h08);
		@(posedge clk) alarms.loop_lock_loss_flags <= 4'h2;
		step(2);
		`CHK(driver_enabled[0], 1'b0)
		rd(16'h000D, 8'h02);
		// Loop A loss is unmasked but driver 0 listens to loop B
		@(posedge clk) alarms.loop_lock_loss_flags <= 4'h1;
		step(2);
		`CHK(driver_enabled[0], 1'b1)
		@(posedge clk) driver_disable_source_select <= 14'h0000;
		step(2);
		`CHK(driver_enabled[0], 1'b0)
		@(posedge clk) driver_disable_source_select <= 14'h0001;
		wr(16'h0142, 8'h0F);
		@(posedge clk) alarms.loop_lock_loss_flags <= 4'h2;
		step(3);
		`CHK(driver_enabled[0], 1'b1)
		@(posedge clk) alarms.loop_lock_loss_flags <= 4'h0;
	endtask
	task t_alarm;
		@(posedge clk) alarms.crystal_input_loss <= 1'b1;
		step(3);
		`CHK(driver_enabled[0], 1'b0)
		rd(16'h000C, 8'h02);
		wr(16'h0141, 8'h40);
		step(3);
		`CHK(driver_enabled[0], 1'b1)
		@(posedge clk) alarms <= '{4'h0, 1'b0, 1'b1};
		step(2);
		`CHK(driver_enabled[0], 1'b0)
		rd(16'h000C, 8'h01);
		@(posedge clk) alarms.calibration_in_progress <= 1'b0;
		wr(16'h0141, 8'h00);
	endtask
	task t_sync;
		wr(16'h0113, 8'h08);
		@(posedge clk) driver_clk_in[0] <= 1'b1;
		@(posedge clk) output_enable_pin_n <= 1'b1;
		step(3);
		`CHK(driver_enabled[0], 1'b1)
		@(posedge clk) driver_clk_in[0] <= 1'b0;
		step(2);
		`CHK(driver_enabled[0], 1'b0)
		`CHK(driver_out[0], 1'b0)
		wr(16'h0113, 8'h00);
		@(posedge clk) output_enable_pin_n <= 1'b0;
		@(posedge clk) driver_clk_in[0] <= 1'b1;
		step(3);
		@(posedge clk) output_enable_pin_n <= 1'b1;
		step(1);
		`CHK(driver_enabled[0], 1'b0)
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_enable();
		t_lock();
		t_alarm();
		t_sync();
		tally_and_finish();
	end
endmodule
bind output_driver_disable_control disable_checker chk_u (.clk, .reset, .reg_req,
	.reg_rdata, .output_enable_pin_n, .alarms, .driver_disable_source_select,
	.driver_clk_in, .driver_out, .driver_enabled);
`default_nettype wire
